//--- src/sai_pkg.sv
package sai_pkg;
    // host register map (apb byte addresses)
    localparam logic [7:0]  CTRL_OFS      = 8'h00;
    localparam logic [7:0]  STATUS_OFS    = 8'h04;
    localparam logic [7:0]  SNAP_OFS      = 8'h08;
    localparam logic [7:0]  CFG_OFS       = 8'h0C;
    // ctrl and cfg fields
    localparam int          CTRL_GO       = 0;
    localparam int          CTRL_CMD_LSB  = 1;
    localparam int          CTRL_ADR_LSB  = 4;
    localparam int          CTRL_DAT_LSB  = 8;
    localparam int          CFG_AUTO      = 0;
    // status fields
    localparam int          ST_BUSY       = 0;
    localparam int          ST_FLAG_LSB   = 1;
    localparam int          ST_RDAT_LSB   = 8;
    localparam int          ST_IRQ        = 16;
    localparam logic [5:0]  FLAGS_RST     = 6'h00;
    // commands
    localparam logic [2:0]  CMD_WRITE     = 3'h0;
    localparam logic [2:0]  CMD_READ      = 3'h1;
    localparam logic [2:0]  CMD_ARB       = 3'h2;
    localparam logic [2:0]  CMD_POLL      = 3'h3;
    localparam logic [2:0]  CMD_SERVICE   = 3'h4;
    localparam logic [2:0]  CMD_CHIP_RST  = 3'h5;
    // device register ports
    localparam logic [2:0]  PORT_DATA     = 3'h0;
    localparam logic [2:0]  PORT_MODE     = 3'h2;
    localparam logic [2:0]  PORT_LIVE     = 3'h4;
    localparam logic [2:0]  PORT_BSTAT    = 3'h5;
    localparam logic [2:0]  PORT_IRQ_RST  = 3'h7;
    // device bit positions
    localparam int          MODE_ARB      = 0;
    localparam int          BS_END_DMA    = 7;
    localparam int          BS_PAR_ERR    = 5;
    localparam int          BS_PHASE_OK   = 3;
    localparam int          BS_BUSY_ERR   = 2;
    localparam int          BS_ACK        = 0;
    localparam int          LV_REQ        = 5;
    localparam int          LV_SEL        = 1;
    // flag positions inside the six sticky flags
    localparam int          FL_END_DMA    = 0;
    localparam int          FL_PAR_ERR    = 1;
    localparam int          FL_BUSY_ERR   = 2;
    localparam int          FL_SEL_BADPAR = 3;
    localparam int          FL_ID_BAD     = 4;
    localparam int          FL_RST_INFER  = 5;
    // snapshot slots and id limit
    localparam logic [1:0]  SNAP_BSTAT    = 2'h0;
    localparam logic [1:0]  SNAP_LIVE     = 2'h1;
    localparam logic [1:0]  SNAP_DATA     = 2'h2;
    localparam logic [1:0]  SNAP_ARB      = 2'h3;
    localparam int          MAX_IDS       = 2;
    // timing
    localparam int          CLK_NS        = 40;
    localparam int          ARB_DELAY_NS  = 2200;
    localparam int          CHIP_RST_NS   = 200;
    localparam int          STROBE_NS     = 160;
    localparam int          ARB_CYC       = (ARB_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int          CHIP_RST_CYC  = (CHIP_RST_NS + CLK_NS - 1) / CLK_NS;
    localparam int          STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0]  ARB_CNT       = 8'(ARB_CYC - 1);
    localparam logic [7:0]  CHIP_RST_CNT  = 8'(CHIP_RST_CYC - 1);
    localparam logic [7:0]  STROBE_CNT    = 8'(STROBE_CYC - 1);

    typedef enum logic [2:0] {
        ST_IDLE, ST_ACCESS, ST_GAP, ST_ARB_WAIT, ST_RST_HOLD
    } sai_state_t;
endpackage : sai_pkg

//--- src/sai_snap_mem.sv
`timescale 1ns/1ns
// four byte snapshots of device registers; read data registered
module sai_snap_mem (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       we,
    input  wire logic [1:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [1:0] raddr,
    output logic      [7:0] rdata
);
    logic [7:0] mem_ff [4];
    logic [7:0] rdata_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                mem_ff[i] <= 8'h00;
            end
            rdata_ff <= 8'h00;
        end else begin
            if (we) begin
                mem_ff[waddr] <= wdata;
            end
            rdata_ff <= mem_ff[raddr];
        end
    end

    assign rdata = rdata_ff;
endmodule : sai_snap_mem

//--- src/sai_host.sv
`timescale 1ns/1ns
// Function
// - host waits at least 2.2 us after arbitration start before reading data.
// - with parity checking on, host checks parity flag after selection.
// - host reads live data to confirm at most two ids asserted.
// - end of process recognised only with ack and strobe overlap 100 ns.
// - target send end confirmed by polling request and acknowledge both false.
module sai_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [2:0]  dev_addr,
    output logic             dev_cs_n,
    output logic             dev_rd_n,
    output logic             dev_wr_n,
    output logic             dev_reset_n,
    output logic      [7:0]  dev_data_out,
    output logic             dev_data_oe,
    input  wire logic [7:0]  dev_data_in,
    input  wire logic        dev_irq
);
    sai_pkg::sai_state_t state_ff, nxt_state;
    logic [2:0]  cmd_ff, nxt_cmd;
    logic [1:0]  step_ff, nxt_step;
    logic [7:0]  cnt_ff, nxt_cnt;
    logic [2:0]  addr_ff, nxt_addr;
    logic        wr_ff, nxt_wr;
    logic [7:0]  wdat_ff, nxt_wdat;
    logic        cs_n_ff, nxt_cs_n;
    logic        rd_n_ff, nxt_rd_n;
    logic        wr_n_ff, nxt_wr_n;
    logic        oe_ff, nxt_oe;
    logic        rstn_ff, nxt_rstn;
    logic [7:0]  rdat_ff, nxt_rdat;
    logic [7:0]  bs_ff, nxt_bs;
    logic [7:0]  lv_ff, nxt_lv;
    logic [7:0]  dat_ff, nxt_dat;
    logic [5:0]  flags_ff, nxt_flags;
    logic        auto_ff, nxt_auto;
    logic [1:0]  sidx_ff, nxt_sidx;
    logic        pready_ff, nxt_pready;
    logic        pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic        snap_we;
    logic [1:0]  snap_waddr;
    logic [7:0]  snap_rdata;
    logic        wr_fire, rd_phase, go;
    logic        launch;
    logic [2:0]  l_addr;
    logic        l_wr;
    logic [7:0]  l_dat;
    logic [5:0]  set_flags, clr_flags;

    function automatic logic too_many_ids(input logic [7:0] d);
        int n;
        n = 0;
        for (int i = 0; i < 8; i++) begin
            n = n + int'(d[i]);
        end
        return n > sai_pkg::MAX_IDS;
    endfunction : too_many_ids

    sai_snap_mem u_snap (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (snap_we),
        .waddr   (snap_waddr),
        .wdata   (rdat_ff),
        .raddr   (sidx_ff),
        .rdata   (snap_rdata)
    );

    // one wait state: the write takes effect at the edge where pready is seen
    assign wr_fire  = psel & penable & pready_ff & pwrite;
    assign rd_phase = psel & penable & ~pready_ff;
    assign go       = wr_fire & (paddr == sai_pkg::CTRL_OFS) & pwdata[sai_pkg::CTRL_GO];

    // snapshot captures happen in the gap after each completed read of the bstat, live or data port
    always_comb begin
        snap_we    = 1'b0;
        snap_waddr = sai_pkg::SNAP_BSTAT;
        if (state_ff == sai_pkg::ST_GAP && !wr_ff) begin
            unique case (addr_ff)
                sai_pkg::PORT_BSTAT: begin
                    snap_we    = 1'b1;
                    snap_waddr = sai_pkg::SNAP_BSTAT;
                end
                sai_pkg::PORT_LIVE: begin
                    snap_we    = 1'b1;
                    snap_waddr = sai_pkg::SNAP_LIVE;
                end
                sai_pkg::PORT_DATA: begin
                    snap_we    = 1'b1;
                    snap_waddr = (cmd_ff == sai_pkg::CMD_ARB) ? sai_pkg::SNAP_ARB
                                                              : sai_pkg::SNAP_DATA;
                end
                default: snap_we = 1'b0;
            endcase
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_cmd   = cmd_ff;
        nxt_step  = step_ff;
        nxt_cnt   = cnt_ff;
        nxt_addr  = addr_ff;
        nxt_wr    = wr_ff;
        nxt_wdat  = wdat_ff;
        nxt_cs_n  = cs_n_ff;
        nxt_rd_n  = rd_n_ff;
        nxt_wr_n  = wr_n_ff;
        nxt_oe    = oe_ff;
        nxt_rstn  = rstn_ff;
        nxt_rdat  = rdat_ff;
        nxt_bs    = bs_ff;
        nxt_lv    = lv_ff;
        nxt_dat   = dat_ff;
        set_flags = 6'h00;
        launch    = 1'b0;
        l_addr    = addr_ff;
        l_wr      = 1'b0;
        l_dat     = wdat_ff;
        unique case (state_ff)
            sai_pkg::ST_IDLE: begin
                nxt_step = 2'h0;
                if (go) begin
                    nxt_cmd  = pwdata[sai_pkg::CTRL_CMD_LSB +: 3];
                    nxt_wdat = pwdata[sai_pkg::CTRL_DAT_LSB +: 8];
                    l_addr   = pwdata[sai_pkg::CTRL_ADR_LSB +: 3];
                    l_dat    = pwdata[sai_pkg::CTRL_DAT_LSB +: 8];
                    unique case (pwdata[sai_pkg::CTRL_CMD_LSB +: 3])
                        sai_pkg::CMD_WRITE: begin
                            launch = 1'b1;
                            l_wr   = 1'b1;
                        end
                        sai_pkg::CMD_READ: launch = 1'b1;
                        sai_pkg::CMD_ARB: begin
                            // device itself waits for bus free and select off
                            launch   = 1'b1;
                            l_wr     = 1'b1;
                            l_addr   = sai_pkg::PORT_MODE;
                            l_dat[sai_pkg::MODE_ARB] = 1'b1;
                        end
                        sai_pkg::CMD_POLL: begin
                            launch = 1'b1;
                            l_addr = sai_pkg::PORT_LIVE;
                        end
                        sai_pkg::CMD_SERVICE: begin
                            launch = 1'b1;
                            l_addr = sai_pkg::PORT_BSTAT;
                        end
                        sai_pkg::CMD_CHIP_RST: begin
                            nxt_rstn  = 1'b0;
                            nxt_cnt   = sai_pkg::CHIP_RST_CNT;
                            nxt_state = sai_pkg::ST_RST_HOLD;
                        end
                        default: nxt_state = sai_pkg::ST_IDLE;
                    endcase
                end else if (auto_ff && dev_irq) begin
                    nxt_cmd = sai_pkg::CMD_SERVICE;
                    launch  = 1'b1;
                    l_addr  = sai_pkg::PORT_BSTAT;
                end
            end
            sai_pkg::ST_ACCESS: begin
                if (cnt_ff == 8'h00) begin
                    if (!wr_ff) begin
                        nxt_rdat = dev_data_in;
                    end
                    nxt_cs_n  = 1'b1;
                    nxt_rd_n  = 1'b1;
                    nxt_wr_n  = 1'b1;
                    nxt_oe    = 1'b0;
                    nxt_state = sai_pkg::ST_GAP;
                end else begin
                    nxt_cnt = cnt_ff - 8'h01;
                end
            end
            sai_pkg::ST_GAP: begin
                nxt_state = sai_pkg::ST_IDLE;
                nxt_step  = step_ff + 2'h1;
                unique case (cmd_ff)
                    sai_pkg::CMD_ARB: begin
                        if (step_ff == 2'h0) begin
                            // software-side arbitration delay before looking at data
                            nxt_cnt   = sai_pkg::ARB_CNT;
                            nxt_state = sai_pkg::ST_ARB_WAIT;
                        end
                    end
                    sai_pkg::CMD_POLL: begin
                        if (step_ff == 2'h0) begin
                            nxt_lv = rdat_ff;
                            launch = 1'b1;
                            l_addr = sai_pkg::PORT_BSTAT;
                        end else if (lv_ff[sai_pkg::LV_REQ] || rdat_ff[sai_pkg::BS_ACK]) begin
                            // keep polling until both handshake lines are false
                            nxt_bs   = rdat_ff;
                            nxt_step = 2'h0;
                            launch   = 1'b1;
                            l_addr   = sai_pkg::PORT_LIVE;
                        end else begin
                            nxt_bs = rdat_ff;
                        end
                    end
                    sai_pkg::CMD_SERVICE: begin
                        // causes are read before the clearing read of the reset port
                        unique case (step_ff)
                            2'h0: begin
                                nxt_bs = rdat_ff;
                                launch = 1'b1;
                                l_addr = sai_pkg::PORT_LIVE;
                            end
                            2'h1: begin
                                nxt_lv = rdat_ff;
                                launch = 1'b1;
                                l_addr = sai_pkg::PORT_DATA;
                            end
                            2'h2: begin
                                nxt_dat = rdat_ff;
                                launch  = 1'b1;
                                l_addr  = sai_pkg::PORT_IRQ_RST;
                            end
                            default: begin
                                // device flags transfer_done_flag only after a full overlap
                                set_flags[sai_pkg::FL_END_DMA]  = bs_ff[sai_pkg::BS_END_DMA];
                                set_flags[sai_pkg::FL_PAR_ERR]  = bs_ff[sai_pkg::BS_PAR_ERR];
                                set_flags[sai_pkg::FL_BUSY_ERR] = bs_ff[sai_pkg::BS_BUSY_ERR];
                                set_flags[sai_pkg::FL_SEL_BADPAR] = lv_ff[sai_pkg::LV_SEL] &
                                    bs_ff[sai_pkg::BS_PAR_ERR];
                                set_flags[sai_pkg::FL_ID_BAD] = lv_ff[sai_pkg::LV_SEL] &
                                    too_many_ids(dat_ff);
                                // nothing else explains the interrupt: a bus reset
                                set_flags[sai_pkg::FL_RST_INFER] =
                                    ~(bs_ff[sai_pkg::BS_END_DMA] | bs_ff[sai_pkg::BS_PAR_ERR] |
                                      bs_ff[sai_pkg::BS_BUSY_ERR] | lv_ff[sai_pkg::LV_SEL] |
                                      ~bs_ff[sai_pkg::BS_PHASE_OK]);
                            end
                        endcase
                    end
                    default: nxt_state = sai_pkg::ST_IDLE;
                endcase
            end
            sai_pkg::ST_ARB_WAIT: begin
                if (cnt_ff == 8'h00) begin
                    launch = 1'b1;
                    l_addr = sai_pkg::PORT_DATA;
                end else begin
                    nxt_cnt = cnt_ff - 8'h01;
                end
            end
            sai_pkg::ST_RST_HOLD: begin
                if (cnt_ff == 8'h00) begin
                    nxt_rstn  = 1'b1;
                    nxt_state = sai_pkg::ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 8'h01;
                end
            end
        endcase
        if (launch) begin
            nxt_addr  = l_addr;
            nxt_wr    = l_wr;
            nxt_wdat  = l_dat;
            nxt_cs_n  = 1'b0;
            nxt_rd_n  = l_wr;
            nxt_wr_n  = ~l_wr;
            nxt_oe    = l_wr;
            nxt_cnt   = sai_pkg::STROBE_CNT;
            nxt_state = sai_pkg::ST_ACCESS;
        end
    end

    // apb side; flags are write-one-to-clear and a same-cycle set wins
    always_comb begin
        nxt_pready  = rd_phase;
        nxt_pslverr = 1'b0;
        nxt_prdata  = prdata_ff;
        nxt_auto    = auto_ff;
        nxt_sidx    = sidx_ff;
        clr_flags   = 6'h00;
        if (rd_phase) begin
            nxt_prdata = 32'h0000_0000;
            unique case (paddr)
                sai_pkg::CTRL_OFS: nxt_prdata = {29'h0, cmd_ff};
                sai_pkg::STATUS_OFS: begin
                    nxt_prdata[sai_pkg::ST_BUSY]               = state_ff != sai_pkg::ST_IDLE;
                    nxt_prdata[sai_pkg::ST_FLAG_LSB +: 6]      = flags_ff;
                    nxt_prdata[sai_pkg::ST_RDAT_LSB +: 8]      = rdat_ff;
                    nxt_prdata[sai_pkg::ST_IRQ]                = dev_irq;
                end
                sai_pkg::SNAP_OFS: nxt_prdata = {24'h0, snap_rdata};
                sai_pkg::CFG_OFS:  nxt_prdata = {31'h0, auto_ff};
                // writes to holes are dropped quietly; only reads report an error
                default:           nxt_pslverr = ~pwrite;
            endcase
        end
        if (wr_fire) begin
            unique case (paddr)
                sai_pkg::STATUS_OFS: clr_flags = pwdata[sai_pkg::ST_FLAG_LSB +: 6];
                sai_pkg::SNAP_OFS:   nxt_sidx  = pwdata[1:0];
                sai_pkg::CFG_OFS:    nxt_auto  = pwdata[sai_pkg::CFG_AUTO];
                default:             nxt_auto  = auto_ff;
            endcase
        end
        nxt_flags = (flags_ff & ~clr_flags) | set_flags;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff   <= sai_pkg::ST_IDLE;
            cmd_ff     <= sai_pkg::CMD_WRITE;
            step_ff    <= 2'h0;
            cnt_ff     <= 8'h00;
            addr_ff    <= 3'h0;
            wr_ff      <= 1'b0;
            wdat_ff    <= 8'h00;
            cs_n_ff    <= 1'b1;
            rd_n_ff    <= 1'b1;
            wr_n_ff    <= 1'b1;
            oe_ff      <= 1'b0;
            rstn_ff    <= 1'b1;
            rdat_ff    <= 8'h00;
            bs_ff      <= 8'h00;
            lv_ff      <= 8'h00;
            dat_ff     <= 8'h00;
            flags_ff   <= sai_pkg::FLAGS_RST;
            auto_ff    <= 1'b0;
            sidx_ff    <= 2'h0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            state_ff   <= nxt_state;
            cmd_ff     <= nxt_cmd;
            step_ff    <= nxt_step;
            cnt_ff     <= nxt_cnt;
            addr_ff    <= nxt_addr;
            wr_ff      <= nxt_wr;
            wdat_ff    <= nxt_wdat;
            cs_n_ff    <= nxt_cs_n;
            rd_n_ff    <= nxt_rd_n;
            wr_n_ff    <= nxt_wr_n;
            oe_ff      <= nxt_oe;
            rstn_ff    <= nxt_rstn;
            rdat_ff    <= nxt_rdat;
            bs_ff      <= nxt_bs;
            lv_ff      <= nxt_lv;
            dat_ff     <= nxt_dat;
            flags_ff   <= nxt_flags;
            auto_ff    <= nxt_auto;
            sidx_ff    <= nxt_sidx;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
        end
    end

    assign prdata       = prdata_ff;
    assign pready       = pready_ff;
    assign pslverr      = pslverr_ff;
    assign dev_addr     = addr_ff;
    assign dev_cs_n     = cs_n_ff;
    assign dev_rd_n     = rd_n_ff;
    assign dev_wr_n     = wr_n_ff;
    assign dev_reset_n  = rstn_ff;
    assign dev_data_out = wdat_ff;
    assign dev_data_oe  = oe_ff;
endmodule : sai_host

//--- sim/sai_dev_model.sv
`timescale 1ns/1ns
module sai_dev_model #(
    parameter logic [7:0] ARB_ID = 8'h80
) (
    input wire logic pclk, dev_cs_n, dev_rd_n, dev_wr_n, dev_reset_n, dev_data_oe, req_line,
    input wire logic [2:0] dev_addr, ev,
    input wire logic [7:0] dev_data_out,
    output logic [7:0] dev_data_in,
    output logic dev_irq
);
    logic [7:0] mode_ff = 8'h00;
    logic [7:0] last_ff = 8'h00;
    logic [7:0] rd_val;
    logic end_dma_ff = 1'h0;
    logic par_ff = 1'h0;
    logic irq_ff = 1'h0;
    wire rd = !dev_cs_n && !dev_rd_n;
    wire irq_set = ev[2] || (ev[0] && mode_ff[1] && mode_ff[3]) || (ev[1] && &mode_ff[5:4]);
    assign dev_irq = irq_ff;
    // a released bus shows the inverse of the last byte, never a stale copy
    assign dev_data_in = rd ? rd_val : ~last_ff;
    always_comb begin
        case (dev_addr)
            sai_pkg::PORT_DATA: rd_val = ARB_ID;
            sai_pkg::PORT_LIVE: rd_val = {ev[2], 1'h1, req_line, 5'h00};
            sai_pkg::PORT_BSTAT: rd_val = {end_dma_ff, 1'h0, par_ff, irq_ff, 4'h8};
            default: rd_val = mode_ff;
        endcase
    end
    always @(posedge pclk) begin
        if (rd) last_ff <= rd_val;
        if (!dev_cs_n && !dev_wr_n && dev_data_oe && dev_addr == sai_pkg::PORT_MODE)
            mode_ff <= dev_data_out;
        if (!mode_ff[1]) end_dma_ff <= 1'h0;
        if (ev[0] && mode_ff[1]) end_dma_ff <= 1'h1;
        if (ev[1] && mode_ff[5]) par_ff <= 1'h1;
        if (irq_set) irq_ff <= 1'h1;
        if (rd && dev_addr == sai_pkg::PORT_IRQ_RST) {irq_ff, par_ff} <= 2'h0;
        if (!dev_reset_n) {mode_ff, end_dma_ff, par_ff, irq_ff} <= '0;
    end
endmodule : sai_dev_model

//--- sim/sai_host_asserts.sv
`timescale 1ns/1ns
module sai_host_asserts (
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic dev_cs_n, dev_rd_n, dev_wr_n, dev_reset_n, dev_data_oe,
    input wire logic [2:0] dev_addr,
    input wire logic [7:0] dev_data_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [6:0] arb_gap_ff, nxt_arb_gap;
    wire arb_wr = !dev_wr_n && dev_addr == sai_pkg::PORT_MODE && dev_data_out[sai_pkg::MODE_ARB];
    // gap counts from the last strobe cycle, so the strobe length is credited
    always_comb nxt_arb_gap = arb_wr ? 7'h00 : arb_gap_ff + 7'(arb_gap_ff != 7'h7F);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) arb_gap_ff <= 7'h7F;
        else arb_gap_ff <= nxt_arb_gap;
    end
    a_ready_wait: assert property ($rose(penable) && psel |=> pready) else $error("no pready");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_err_read: assert property (pslverr |-> pready && !pwrite) else $error("bad pslverr");
    a_strobe_len: assert property ($fell(dev_cs_n) |-> !dev_cs_n [*4] ##1 dev_cs_n)
        else $error("strobe length");
    a_one_strobe: assert property (!dev_cs_n |-> dev_rd_n != dev_wr_n) else $error("strobe kind");
    a_drive_wr: assert property (dev_data_oe == !dev_wr_n) else $error("drive enable");
    a_addr_hold: assert property (!dev_cs_n ##1 !dev_cs_n |-> $stable(dev_addr))
        else $error("addr moved");
    a_chip_rst: assert property ($fell(dev_reset_n) |-> !dev_reset_n [*5] ##1 dev_reset_n)
        else $error("chip reset length");
    a_arb_delay: assert property ($fell(dev_rd_n) && dev_addr == sai_pkg::PORT_DATA |->
        arb_gap_ff >= 7'(sai_pkg::ARB_CYC - sai_pkg::STROBE_CYC)) else $error("early data read");
    c_slverr: cover property (pready && pslverr);
    c_rst: cover property ($fell(dev_reset_n));
    c_clr_irq: cover property (!dev_rd_n && dev_addr == sai_pkg::PORT_IRQ_RST);
endmodule : sai_host_asserts
bind sai_host sai_host_asserts chk_u (.*);

//--- sim/sai_host_test.sv
`timescale 1ns/1ns
module sai_host_test;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, req_line = 1'h0;
    logic pready, pslverr, err, dev_cs_n, dev_rd_n, dev_wr_n, dev_reset_n, dev_data_oe, dev_irq;
    logic [7:0] paddr = 8'h00, dev_data_out, dev_data_in;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [2:0] dev_addr, ev = 3'h0;
    logic [5:0] flg [3] = '{6'h01, 6'h02, 6'h20};
    int miscompares = 0, n_checks = 0;
    time t0;
    sai_host dut_u (.*);
    sai_dev_model dev_u (.*);
    initial forever #20 pclk = ~pclk;
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            miscompares++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic st;
        apb(1'h0, sai_pkg::STATUS_OFS, 32'h0);
    endtask : st
    task automatic run(input logic [2:0] c, input logic [2:0] p, input logic [7:0] v);
        apb(1'h1, sai_pkg::CTRL_OFS, {16'h0, v, 1'h0, p, c, 1'h1});
        for (int i = 0; i < 300; i++) begin
            st();
            if (rd[0] === 1'h0) return;
        end
        miscompares++;
        end_of_test();
    endtask : run
    task automatic pulse(input logic [2:0] v);
        @(posedge pclk);
        ev <= v;
        @(posedge pclk);
        ev <= 3'h0;
    endtask : pulse
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        st();
        chk(rd, 32'h0);
        apb(1'h0, 8'h10, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'h1, 8'h10, 32'h0);
        chk(32'(err), 32'h0);
        // end of process, parity error, bus reset in turn
        for (int i = 0; i < 3; i++) begin
            run(sai_pkg::CMD_WRITE, sai_pkg::PORT_MODE, 8'h3A);
            pulse(3'(1 << i));
            st();
            chk(32'(rd[16]), 32'h1);
            run(sai_pkg::CMD_SERVICE, 3'h0, 8'h00);
            st();
            chk(32'({rd[16], rd[6:1]}), 32'(flg[i]));
            apb(1'h1, sai_pkg::STATUS_OFS, 32'h7E);
            st();
            chk(32'(rd[6:1]), 32'h0);
            run(sai_pkg::CMD_WRITE, sai_pkg::PORT_MODE, 8'h00);
        end
        run(sai_pkg::CMD_WRITE, sai_pkg::PORT_MODE, 8'h02);
        pulse(3'h3);
        st();
        chk(32'(rd[16]), 32'h0);
        pulse(3'h4);
        st();
        chk(32'(rd[16]), 32'h1);
        run(sai_pkg::CMD_CHIP_RST, 3'h0, 8'h00);
        chk(32'(dev_irq), 32'h0);
        run(sai_pkg::CMD_ARB, 3'h0, 8'h40);
        chk(32'(dev_u.mode_ff), 32'h41);
        apb(1'h1, sai_pkg::SNAP_OFS, 32'h3);
        apb(1'h0, sai_pkg::SNAP_OFS, 32'h0);
        chk(32'(rd[7:0]), 32'h80);
        req_line <= 1'h1;
        t0 = $time;
        fork
            run(sai_pkg::CMD_POLL, 3'h0, 8'h00);
            begin
                repeat (50) @(posedge pclk);
                req_line <= 1'h0;
            end
        join
        chk(32'($time - t0 > 2000), 32'h1);
        // automatic service on a bus reset; the go below arrives while busy and is dropped
        apb(1'h1, sai_pkg::CFG_OFS, 32'h1);
        pulse(3'h4);
        run(sai_pkg::CMD_READ, sai_pkg::PORT_DATA, 8'h00);
        st();
        chk(rd, 32'h0000_4140);
        apb(1'h0, sai_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'(sai_pkg::CMD_SERVICE));
        end_of_test();
    end
endmodule : sai_host_test
